// ===== logic/poepd_ctrl.sv
`timescale 1ns/1ps
module poepd_ctrl #(
	parameter int FLAG_DELAY_CYCLES = poepd_pkg::FLAG_DELAY_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [poepd_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog front end
	input wire logic above_turn_on_lockout_threshold,
	input wire logic [2:0] class_event_count,
	input wire logic pair_set_a_sense,
	input wire logic pair_set_b_sense,
	input wire logic adapter_override_in,
	// power path
	output logic isolation_switch_on,
	output logic aux_supply_on,
	output logic detect_class_enable,
	// open-drain flags
	input wire logic type2_power_flag_n_in,
	output logic type2_power_flag_n_out,
	output logic type2_power_flag_n_oe,
	input wire logic high_power_flag_n_in,
	output logic high_power_flag_n_out,
	output logic high_power_flag_n_oe,
	input wire logic four_pair_type2_flag_n_in,
	output logic four_pair_type2_flag_n_out,
	output logic four_pair_type2_flag_n_oe,
	input wire logic four_pair_high_power_flag_n_in,
	output logic four_pair_high_power_flag_n_out,
	output logic four_pair_high_power_flag_n_oe,
	// interrupt
	output logic irq
);
	generate
		if (FLAG_DELAY_CYCLES < 2)
		begin : g_bad
			$error("poepd_ctrl: FLAG_DELAY_CYCLES must be at least 2");
		end
	endgenerate

	typedef struct packed {
		poepd_pkg::poepd_state_t st;
		logic above_q;
		logic ovr_q;
		logic port_en;
		logic [poepd_pkg::IRQ_W-1:0] irq_stat;
		logic [poepd_pkg::IRQ_W-1:0] irq_en;
		logic [31:0] rdata;
		logic slverr;
		logic [3:0] oe;
		logic iso;
		logic aux;
		logic det;
	} poepd_main_t;

	poepd_main_t r, nx;
	poepd_flag_if fl ();

	poepd_flag_latch #(
		.DELAY_CYCLES(FLAG_DELAY_CYCLES)
	) u_latch (
		.pclk(pclk),
		.presetn(presetn),
		.fl(fl.lat)
	);

	logic setup_ph;
	logic access_ph;
	logic turn_on;
	logic rearm;
	logic [poepd_pkg::IRQ_W-1:0] ev;
	logic [3:0] pins;

	assign setup_ph = psel && !penable;
	assign access_ph = psel && penable;
	assign pins = {four_pair_high_power_flag_n_in, four_pair_type2_flag_n_in, high_power_flag_n_in,
		type2_power_flag_n_in};

	function automatic logic addr_known(input logic [poepd_pkg::ADDR_W-1:0] a);
		return a == poepd_pkg::CTRL_ADDR || a == poepd_pkg::STATUS_ADDR || a == poepd_pkg::IRQ_STATUS_ADDR
			|| a == poepd_pkg::IRQ_ENABLE_ADDR || a == poepd_pkg::IRQ_CLEAR_ADDR;
	endfunction : addr_known

	always_comb
	begin
		nx = r;
		turn_on = 1'b0;
		rearm = 1'b0;
		ev = '0;
		nx.above_q = above_turn_on_lockout_threshold;
		nx.ovr_q = adapter_override_in;

		// power sequencing; the override outranks everything
		if (adapter_override_in)
		begin
			nx.st = poepd_pkg::ST_ADAPTER;
		end
		else
		begin
			case (r.st)
				poepd_pkg::ST_DETECT:
				begin
					// a threshold already high after the override ends needs a fresh crossing
					if (r.port_en && above_turn_on_lockout_threshold && !r.above_q)
					begin
						nx.st = poepd_pkg::ST_INRUSH;
						turn_on = 1'b1;
					end
				end
				poepd_pkg::ST_INRUSH:
				begin
					if (!above_turn_on_lockout_threshold)
					begin
						nx.st = poepd_pkg::ST_DETECT;
						rearm = 1'b1;
					end
					else if (fl.valid)
					begin
						nx.st = poepd_pkg::ST_POWERED;
					end
				end
				poepd_pkg::ST_POWERED:
				begin
					if (!above_turn_on_lockout_threshold)
					begin
						nx.st = poepd_pkg::ST_DETECT;
						rearm = 1'b1;
					end
				end
				poepd_pkg::ST_ADAPTER:
				begin
					nx.st = poepd_pkg::ST_DETECT;
					rearm = 1'b1;
				end
				default:
				begin
					nx.st = poepd_pkg::ST_DETECT;
					rearm = 1'b1;
				end
			endcase
		end

		// outputs follow the next state so they change with it
		nx.iso = (nx.st == poepd_pkg::ST_INRUSH) || (nx.st == poepd_pkg::ST_POWERED);
		nx.aux = nx.st != poepd_pkg::ST_DETECT;
		nx.det = (nx.st == poepd_pkg::ST_DETECT) && r.port_en && !adapter_override_in;
		if (nx.st == poepd_pkg::ST_ADAPTER)
		begin
			nx.oe = 4'hf;
		end
		else if (nx.st == poepd_pkg::ST_POWERED)
		begin
			nx.oe = fl.drive;
		end
		else
		begin
			// flags stay open until the post-inrush delay ends
			nx.oe = 4'h0;
		end

		// events
		ev[poepd_pkg::IRQ_TURN_ON] = turn_on;
		ev[poepd_pkg::IRQ_DECLARED] = (r.st == poepd_pkg::ST_INRUSH) && (nx.st == poepd_pkg::ST_POWERED);
		ev[poepd_pkg::IRQ_OVR_ON] = adapter_override_in && !r.ovr_q;
		ev[poepd_pkg::IRQ_OVR_OFF] = !adapter_override_in && r.ovr_q;
		ev[poepd_pkg::IRQ_BAD_COUNT] = turn_on && poepd_pkg::poepd_count_bad(class_event_count);

		// apb: data prepared in setup, answered in access
		if (setup_ph)
		begin
			nx.slverr = !addr_known(paddr);
			nx.rdata = '0;
			if (!pwrite)
			begin
				case (paddr)
					poepd_pkg::CTRL_ADDR: nx.rdata[poepd_pkg::CTRL_PORT_EN_BIT] = r.port_en;
					poepd_pkg::STATUS_ADDR:
					begin
						nx.rdata[poepd_pkg::ST_STATE_LSB +: 2] = r.st;
						nx.rdata[poepd_pkg::ST_PIN_LSB +: 4] = pins;
						nx.rdata[poepd_pkg::ST_DRIVE_LSB +: 4] = fl.drive;
						nx.rdata[poepd_pkg::ST_VALID_BIT] = fl.valid;
						nx.rdata[poepd_pkg::ST_COUNT_LSB +: 3] = class_event_count;
						nx.rdata[poepd_pkg::ST_SENSE_A_BIT] = pair_set_a_sense;
						nx.rdata[poepd_pkg::ST_SENSE_B_BIT] = pair_set_b_sense;
						nx.rdata[poepd_pkg::ST_OVERRIDE_BIT] = adapter_override_in;
						nx.rdata[poepd_pkg::ST_ABOVE_BIT] = above_turn_on_lockout_threshold;
					end
					poepd_pkg::IRQ_STATUS_ADDR: nx.rdata[poepd_pkg::IRQ_W-1:0] = r.irq_stat;
					poepd_pkg::IRQ_ENABLE_ADDR: nx.rdata[poepd_pkg::IRQ_W-1:0] = r.irq_en;
					default: nx.rdata = '0;
				endcase
			end
		end

		if (access_ph && pwrite)
		begin
			case (paddr)
				poepd_pkg::CTRL_ADDR: nx.port_en = pwdata[poepd_pkg::CTRL_PORT_EN_BIT];
				poepd_pkg::IRQ_ENABLE_ADDR: nx.irq_en = pwdata[poepd_pkg::IRQ_W-1:0];
				poepd_pkg::IRQ_CLEAR_ADDR: nx.irq_stat = r.irq_stat & ~pwdata[poepd_pkg::IRQ_W-1:0];
				default: nx.irq_en = r.irq_en;
			endcase
		end
		// a new event beats a clear in the same cycle
		nx.irq_stat = nx.irq_stat | ev;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= '{st: poepd_pkg::ST_DETECT, above_q: 1'b0, ovr_q: 1'b0, port_en: poepd_pkg::CTRL_PORT_EN_RST,
				irq_stat: '0, irq_en: poepd_pkg::IRQ_ENABLE_RST, rdata: '0, slverr: 1'b0, oe: 4'h0,
				iso: 1'b0, aux: 1'b0, det: 1'b0};
		end
		else
		begin
			r <= nx;
		end
	end

	assign fl.turn_on = turn_on;
	assign fl.rearm = rearm;
	assign fl.class_count = class_event_count;
	assign fl.sense_a = pair_set_a_sense;
	assign fl.sense_b = pair_set_b_sense;

	assign prdata = r.rdata;
	assign pready = access_ph;
	assign pslverr = access_ph && r.slverr;
	assign isolation_switch_on = r.iso;
	assign aux_supply_on = r.aux;
	assign detect_class_enable = r.det;
	// open drain: only ever pulls low
	assign type2_power_flag_n_out = 1'b0;
	assign high_power_flag_n_out = 1'b0;
	assign four_pair_type2_flag_n_out = 1'b0;
	assign four_pair_high_power_flag_n_out = 1'b0;
	assign type2_power_flag_n_oe = r.oe[poepd_pkg::FLG_TYPE2];
	assign high_power_flag_n_oe = r.oe[poepd_pkg::FLG_HIGH];
	assign four_pair_type2_flag_n_oe = r.oe[poepd_pkg::FLG_4P_TYPE2];
	assign four_pair_high_power_flag_n_oe = r.oe[poepd_pkg::FLG_4P_HIGH];
	assign irq = |(r.irq_stat & r.irq_en);

	property p_normal;
		@(posedge pclk) disable iff (!presetn)
		(!adapter_override_in && r.st == poepd_pkg::ST_DETECT && r.port_en && !turn_on) |=> detect_class_enable;
	endproperty
	a_normal: assert property (p_normal) else $error("detection not running in normal mode");

	property p_iso_off;
		@(posedge pclk) disable iff (!presetn)
		adapter_override_in |=> !isolation_switch_on;
	endproperty
	a_iso_off: assert property (p_iso_off) else $error("isolation switch on under override");

	property p_flags_low;
		@(posedge pclk) disable iff (!presetn)
		adapter_override_in |=> (type2_power_flag_n_oe && high_power_flag_n_oe && four_pair_type2_flag_n_oe
			&& four_pair_high_power_flag_n_oe);
	endproperty
	a_flags_low: assert property (p_flags_low) else $error("flags not all low under override");

	property p_aux_on;
		@(posedge pclk) disable iff (!presetn)
		adapter_override_in [*2] |-> aux_supply_on;
	endproperty
	a_aux_on: assert property (p_aux_on) else $error("aux supply off under override");

	property p_no_detect;
		@(posedge pclk) disable iff (!presetn)
		adapter_override_in |=> !detect_class_enable && !fl.turn_on;
	endproperty
	a_no_detect: assert property (p_no_detect) else $error("detection enabled under override");

	property p_inrush;
		@(posedge pclk) disable iff (!presetn)
		fl.turn_on |=> isolation_switch_on && $past(above_turn_on_lockout_threshold) && !$past(r.above_q);
	endproperty
	a_inrush: assert property (p_inrush) else $error("inrush not started on threshold crossing");

	property p_open_early;
		@(posedge pclk) disable iff (!presetn)
		(r.st == poepd_pkg::ST_INRUSH && !fl.valid && !adapter_override_in) |=> (r.oe == 4'h0);
	endproperty
	a_open_early: assert property (p_open_early) else $error("flags declared before delay");

	property p_show;
		@(posedge pclk) disable iff (!presetn)
		(r.st == poepd_pkg::ST_POWERED) |-> (r.oe == fl.drive);
	endproperty
	a_show: assert property (p_show) else $error("flag pins differ from latched value");

	property p_release;
		@(posedge pclk) disable iff (!presetn)
		(r.st == poepd_pkg::ST_ADAPTER && !adapter_override_in)
			|=> (r.st == poepd_pkg::ST_DETECT) && !isolation_switch_on && (r.oe == 4'h0) && !fl.valid;
	endproperty
	a_release: assert property (p_release) else $error("override release did not return to detection");

	property p_powered_stays;
		@(posedge pclk) disable iff (!presetn)
		(r.st == poepd_pkg::ST_POWERED && !adapter_override_in && above_turn_on_lockout_threshold)
			|=> isolation_switch_on && !detect_class_enable;
	endproperty
	a_powered_stays: assert property (p_powered_stays) else $error("powered state left without cause");

	property p_wait_valid;
		@(posedge pclk) disable iff (!presetn)
		(r.st == poepd_pkg::ST_INRUSH && !fl.valid) |=> (r.st != poepd_pkg::ST_POWERED);
	endproperty
	a_wait_valid: assert property (p_wait_valid) else $error("powered before flag delay ended");

	property p_single_turn_on;
		@(posedge pclk) disable iff (!presetn)
		(r.st != poepd_pkg::ST_DETECT) |-> !turn_on;
	endproperty
	a_single_turn_on: assert property (p_single_turn_on) else $error("second turn-on without power loss");

	// the turn-on event must survive a clear written in the same cycle
	property p_event_sticky;
		@(posedge pclk) disable iff (!presetn)
		turn_on |=> r.irq_stat[poepd_pkg::IRQ_TURN_ON];
	endproperty
	a_event_sticky: assert property (p_event_sticky) else $error("turn-on event lost");

	c_turn_on: cover property (@(posedge pclk) disable iff (!presetn) fl.turn_on);
	c_override: cover property (@(posedge pclk) disable iff (!presetn) $rose(adapter_override_in));
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule : poepd_ctrl

// ===== logic/poepd_pkg.sv
package poepd_pkg;

	// clock and timing
	localparam int CLK_HZ = 40_000_000;
	localparam int FLAG_DELAY_MS = 80;
	// least time, exact at this rate
	localparam int FLAG_DELAY_CYCLES = FLAG_DELAY_MS * (CLK_HZ / 1000);

	// apb map (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h08;
	localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h0c;
	localparam logic [7:0] IRQ_CLEAR_ADDR = 8'h10;

	// ctrl fields and reset
	localparam int CTRL_PORT_EN_BIT = 0;
	localparam logic CTRL_PORT_EN_RST = 1'b1;

	// status fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_PIN_LSB = 2;
	localparam int ST_DRIVE_LSB = 6;
	localparam int ST_VALID_BIT = 10;
	localparam int ST_COUNT_LSB = 11;
	localparam int ST_SENSE_A_BIT = 14;
	localparam int ST_SENSE_B_BIT = 15;
	localparam int ST_OVERRIDE_BIT = 16;
	localparam int ST_ABOVE_BIT = 17;

	// interrupt bits
	localparam int IRQ_W = 5;
	localparam int IRQ_TURN_ON = 0;
	localparam int IRQ_DECLARED = 1;
	localparam int IRQ_OVR_ON = 2;
	localparam int IRQ_OVR_OFF = 3;
	localparam int IRQ_BAD_COUNT = 4;
	localparam logic [4:0] IRQ_ENABLE_RST = 5'h00;

	// flag drive bits, 1 = pull pin low
	localparam int FLG_TYPE2 = 0;
	localparam int FLG_HIGH = 1;
	localparam int FLG_4P_TYPE2 = 2;
	localparam int FLG_4P_HIGH = 3;

	typedef enum logic [1:0] {
		ST_DETECT = 2'b00,
		ST_INRUSH = 2'b01,
		ST_POWERED = 2'b10,
		ST_ADAPTER = 2'b11
	} poepd_state_t;

	function automatic logic [3:0] poepd_flag_decode(input logic [2:0] cnt, input logic sa, input logic sb);
		logic [3:0] d;
		d = 4'h0;
		case (cnt)
			3'h2: d = {1'b0, sa & sb, 2'b01};
			3'h3: d = {1'b0, sa & sb, 2'b11};
			3'h4: d = 4'h7;
			3'h6: d = 4'hf;
			default: d = 4'h0;
		endcase
		return d;
	endfunction : poepd_flag_decode

	function automatic logic poepd_count_bad(input logic [2:0] cnt);
		return (cnt == 3'h0) || (cnt == 3'h5) || (cnt == 3'h7);
	endfunction : poepd_count_bad

endpackage : poepd_pkg

// ===== logic/poepd_flag_if.sv
`timescale 1ns/1ps
interface poepd_flag_if;
	logic turn_on;
	logic rearm;
	logic [2:0] class_count;
	logic sense_a;
	logic sense_b;
	logic [3:0] drive;
	logic valid;

	modport ctl (output turn_on, output rearm, output class_count, output sense_a, output sense_b,
		input drive, input valid);
	modport lat (input turn_on, input rearm, input class_count, input sense_a, input sense_b,
		output drive, output valid);
endinterface : poepd_flag_if

// ===== logic/poepd_flag_latch.sv
`timescale 1ns/1ps
module poepd_flag_latch #(
	parameter int DELAY_CYCLES = poepd_pkg::FLAG_DELAY_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// link to controller
	poepd_flag_if.lat fl
);
	localparam int CW = $clog2(DELAY_CYCLES + 1);

	generate
		if (DELAY_CYCLES < 2)
		begin : g_bad
			$error("poepd_flag_latch: DELAY_CYCLES must be at least 2");
		end
	endgenerate

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic [3:0] drive;
		logic armed;
		logic valid;
	} poepd_lat_t;

	poepd_lat_t r, nx;

	always_comb
	begin
		nx = r;
		if (fl.rearm)
		begin
			nx = '0;
		end
		else if (fl.turn_on)
		begin
			// captured once; sense pins are not looked at again
			nx.drive = poepd_pkg::poepd_flag_decode(fl.class_count, fl.sense_a, fl.sense_b);
			nx.cnt = '0;
			nx.armed = 1'b1;
			nx.valid = 1'b0;
		end
		else if (r.armed && !r.valid)
		begin
			nx.cnt = r.cnt + CW'(1);
			if (r.cnt == CW'(DELAY_CYCLES - 1))
			begin
				nx.valid = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= '0;
		end
		else
		begin
			r <= nx;
		end
	end

	assign fl.drive = r.drive;
	assign fl.valid = r.valid;

	property p_capture;
		@(posedge pclk) disable iff (!presetn)
		(fl.turn_on && !fl.rearm) |=> (fl.drive == poepd_pkg::poepd_flag_decode($past(fl.class_count),
			$past(fl.sense_a), $past(fl.sense_b))) && !fl.valid;
	endproperty
	a_capture: assert property (p_capture) else $error("flags not captured at turn-on");

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		(fl.valid && !fl.turn_on && !fl.rearm) |=> $stable(fl.drive) && fl.valid;
	endproperty
	a_hold: assert property (p_hold) else $error("latched flags changed");

	property p_delay;
		@(posedge pclk) disable iff (!presetn)
		$rose(fl.valid) |-> $past(r.cnt) == CW'(DELAY_CYCLES - 1);
	endproperty
	a_delay: assert property (p_delay) else $error("flags declared at wrong time");

	property p_once;
		@(posedge pclk) disable iff (!presetn)
		(!fl.turn_on && !fl.rearm) |=> $stable(fl.drive);
	endproperty
	a_once: assert property (p_once) else $error("flags changed without turn-on");

	c_declared: cover property (@(posedge pclk) disable iff (!presetn) $rose(fl.valid));
	c_six: cover property (@(posedge pclk) disable iff (!presetn) fl.turn_on && fl.class_count == 3'h6);
endmodule : poepd_flag_latch

// ===== verif/poepd_pse_model.sv
`timescale 1ns/1ps
module poepd_pse_model (
	// clock
	input wire logic pclk,
	// levels requested by the bench
	input wire logic req_above,
	input wire logic [2:0] req_count,
	input wire logic req_sense_a,
	input wire logic req_sense_b,
	// front end levels seen by the block
	output logic above,
	output logic [2:0] class_count,
	output logic sense_a,
	output logic sense_b,
	// open-drain flag pins
	input wire logic [3:0] flag_out,
	input wire logic [3:0] flag_oe,
	output logic [3:0] flag_pin
);
	// levels move just after an edge, like a real comparator output;
	// no start values here, the block is held in reset over the first edge
	always @(posedge pclk)
	begin
		above <= req_above;
		class_count <= req_count;
		sense_a <= req_sense_a;
		sense_b <= req_sense_b;
	end

	// board pull-ups hold released flag lines high
	assign flag_pin = (flag_oe & flag_out) | ~flag_oe;
endmodule : poepd_pse_model

// ===== verif/tb_poe_pd_flag_and_adapter_override.sv
`timescale 1ns/1ps
module tb_poe_pd_flag_and_adapter_override;
	localparam int DLY = 20;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic req_above = 1'b0;
	logic [2:0] req_count = 3'h1;
	logic req_a = 1'b0;
	logic req_b = 1'b0;
	logic ovr = 1'b0;
	logic above;
	logic [2:0] cnt;
	logic sa;
	logic sb;
	logic iso;
	logic aux;
	logic det;
	logic irq;
	logic [3:0] oe;
	logic [3:0] fout;
	logic [3:0] pin;
	logic [31:0] rd;
	logic err;
	int num_errors = 0;
	int cmp_count = 0;
	// {count, sense a, sense b}
	logic [4:0] cases [11] = '{5'h04, 5'h0a, 5'h09, 5'h0b, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h13, 5'h1b, 5'h07};

	always #12.5 pclk = ~pclk;

	poepd_pse_model pse (.pclk(pclk), .req_above(req_above), .req_count(req_count), .req_sense_a(req_a),
		.req_sense_b(req_b), .above(above), .class_count(cnt), .sense_a(sa), .sense_b(sb),
		.flag_out(fout), .flag_oe(oe), .flag_pin(pin));

	poepd_ctrl #(.FLAG_DELAY_CYCLES(DLY)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.above_turn_on_lockout_threshold(above), .class_event_count(cnt), .pair_set_a_sense(sa),
		.pair_set_b_sense(sb), .adapter_override_in(ovr), .isolation_switch_on(iso), .aux_supply_on(aux),
		.detect_class_enable(det), .type2_power_flag_n_in(pin[0]), .type2_power_flag_n_out(fout[0]),
		.type2_power_flag_n_oe(oe[0]), .high_power_flag_n_in(pin[1]), .high_power_flag_n_out(fout[1]),
		.high_power_flag_n_oe(oe[1]), .four_pair_type2_flag_n_in(pin[2]), .four_pair_type2_flag_n_out(fout[2]),
		.four_pair_type2_flag_n_oe(oe[2]), .four_pair_high_power_flag_n_in(pin[3]),
		.four_pair_high_power_flag_n_out(fout[3]), .four_pair_high_power_flag_n_oe(oe[3]), .irq(irq));

	task automatic report_and_stop();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			// no wait-state count assumed; only the watchdog ends a hang
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb

	task automatic edges(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : edges

	function automatic logic [3:0] exp_flags(input logic [2:0] c, input logic a, input logic b);
		case (c)
			3'h2: return {1'b0, a & b, 2'b01};
			3'h3: return {1'b0, a & b, 2'b11};
			3'h4: return 4'h7;
			3'h6: return 4'hf;
			default: return 4'h0;
		endcase
	endfunction : exp_flags

	task automatic power_on(input logic [2:0] c, input logic a, input logic b);
		@(posedge pclk);
		req_count <= c;
		req_a <= a;
		req_b <= b;
		req_above <= 1'b1;
		edges(3);
		check({iso, aux, det}, 3'b110);
		// turn-on edge was one edge back; the delay's last edge still shows open flags
		edges(DLY - 1);
		check(oe, 4'h0);
		edges(1);
		check(oe, exp_flags(c, a, b));
		check(pin, 4'hf ^ exp_flags(c, a, b));
		@(posedge pclk);
		req_a <= ~a;
		req_b <= ~b;
		req_count <= 3'h6;
		edges(4);
		check(oe, exp_flags(c, a, b));
		apb(1'b0, poepd_pkg::STATUS_ADDR, 32'h0);
		check(rd[poepd_pkg::ST_DRIVE_LSB +: 4], exp_flags(c, a, b));
		check(rd[poepd_pkg::ST_VALID_BIT], 1'b1);
	endtask : power_on

	task automatic power_off();
		@(posedge pclk);
		req_above <= 1'b0;
		edges(4);
		check({iso, aux, oe}, 6'h00);
	endtask : power_off

	initial
	begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		report_and_stop();
	end

	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		edges(2);
		check({iso, aux, det, oe}, 7'h10);
		apb(1'b0, poepd_pkg::CTRL_ADDR, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, poepd_pkg::IRQ_ENABLE_ADDR, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, 8'h20, 32'hffffffff);
		check(err, 1'b1);
		apb(1'b0, 8'h20, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0);
		apb(1'b1, poepd_pkg::STATUS_ADDR, 32'hffffffff);
		apb(1'b0, poepd_pkg::STATUS_ADDR, 32'h0);
		check({err, rd[5:0]}, 7'h3c);
		for (int i = 0; i < 11; i++)
		begin
			power_on(cases[i][4:2], cases[i][1], cases[i][0]);
			power_off();
		end
		// interrupt raised, masked and cleared
		apb(1'b1, poepd_pkg::IRQ_CLEAR_ADDR, 32'h1f);
		apb(1'b1, poepd_pkg::IRQ_ENABLE_ADDR, 32'h1 << poepd_pkg::IRQ_TURN_ON);
		check(irq, 1'b0);
		power_on(3'h5, 1'b1, 1'b1);
		check(irq, 1'b1);
		apb(1'b0, poepd_pkg::IRQ_STATUS_ADDR, 32'h0);
		// turn-on, flags declared and the reserved count
		check(rd, 32'h13);
		apb(1'b1, poepd_pkg::IRQ_ENABLE_ADDR, 32'h0);
		check(irq, 1'b0);
		apb(1'b1, poepd_pkg::IRQ_ENABLE_ADDR, 32'h1);
		check(irq, 1'b1);
		apb(1'b1, poepd_pkg::IRQ_CLEAR_ADDR, 32'h1);
		check(irq, 1'b0);
		power_off();
		// port disabled refuses turn-on
		apb(1'b1, poepd_pkg::CTRL_ADDR, 32'h0);
		edges(2);
		check(det, 1'b0);
		@(posedge pclk);
		req_above <= 1'b1;
		edges(4);
		check(iso, 1'b0);
		power_off();
		apb(1'b1, poepd_pkg::CTRL_ADDR, 32'h1);
		// override while powered, then a crossing under override
		power_on(3'h3, 1'b1, 1'b0);
		@(posedge pclk);
		ovr <= 1'b1;
		edges(3);
		check(iso, 1'b0);
		check(oe, 4'hf);
		check(aux, 1'b1);
		check(det, 1'b0);
		// input falls under override: the forced outputs stay
		@(posedge pclk);
		req_above <= 1'b0;
		edges(4);
		check({iso, oe}, 5'h0f);
		@(posedge pclk);
		req_above <= 1'b1;
		edges(4);
		check({iso, aux, det, oe}, 7'h2f);
		@(posedge pclk);
		ovr <= 1'b0;
		edges(3);
		check({iso, aux, det, oe}, 7'h10);
		power_off();
		power_on(3'h2, 1'b1, 1'b1);
		power_off();
		report_and_stop();
	end
endmodule : tb_poe_pd_flag_and_adapter_override
